// [inc/rftd_regs.svh]
// register offsets, field positions and reset values of the driver config bank
// What this block does
// RL1 - bit 7 of the driver mode register inverts what pin b drives.
// RL2 - bit 6 of the driver mode register inverts what pin a drives.
// RL3 - bit 3 of the driver mode register enables both driver pins together.
// RL4 - bits 2 to 0 select open-drain, push-pull, high-impedance or fixed level.
// RL5 - software never writes output mode codes 011b or 110b.
// RL6 - bits 7 to 6 of amplitude pick a 100, 250, 500 or 1000 mV supply drop.
// RL7 - the maximum-carrier bit forces full carrier and ignores the drop field.
// RL8 - bits 4 to 0 of amplitude hold the residual carrier percentage.
// RL9 - bits 7 to 4 of modulation control give overshoot length in carrier clocks.
// RL10 - the modulation invert bit inverts the selected modulation signal.
// RL11 - the source selector picks none, internal envelope, external input or reserved.
// RL12 - bits 7 to 4 of the load register hold the first overshoot timer value.
// RL13 - bits 3 to 0 of the load register hold the factory load-current trim.
// RL14 - the four registers sit at consecutive word indices 28h to 2Bh, byte addresses A0h to ACh.
// RL15 - reserved bits ignore writes and read back as zero.
`ifndef RFTD_REGS_SVH
`define RFTD_REGS_SVH
`define RFTD_IDX_DRV_MODE   8'h28
`define RFTD_IDX_AMPLITUDE  8'h29
`define RFTD_IDX_MOD_CTRL   8'h2A
`define RFTD_IDX_LOAD_TRIM  8'h2B
`define RFTD_MASK_DRV_MODE  8'hCF
`define RFTD_MASK_AMPLITUDE 8'hDF
`define RFTD_MASK_MOD_CTRL  8'hFF
`define RFTD_MASK_LOAD_TRIM 8'hFF
`define RFTD_RST_DRV_MODE   8'h00
`define RFTD_RST_AMPLITUDE  8'h00
`define RFTD_RST_MOD_CTRL   8'h00
`define RFTD_RST_LOAD_TRIM  8'h00
`define RFTD_MODE_OPEN_DRAIN 3'h0
`define RFTD_MODE_PUSH_PULL  3'h1
`define RFTD_MODE_HIGH_Z     3'h2
`define RFTD_MODE_BAD_A      3'h3
`define RFTD_MODE_FIX_LOW    3'h4
`define RFTD_MODE_FIX_HIGH   3'h5
`define RFTD_MODE_BAD_B      3'h6
`define RFTD_DROP_MV_0      11'd100
`define RFTD_DROP_MV_1      11'd250
`define RFTD_DROP_MV_2      11'd500
`define RFTD_DROP_MV_3      11'd1000
`endif

// [inc/rftd_pkg.sv]
// types of the driver config bank
package rftd_pkg;
  typedef enum logic [1:0]
  {
    RFTD_SRC_NONE     = 2'h0,
    RFTD_SRC_ENVELOPE = 2'h1,
    RFTD_SRC_EXTERNAL = 2'h2,
    RFTD_SRC_RESERVED = 2'h3
  } rftd_src_t;

  typedef struct packed
  {
    logic       pin_b_invert;
    logic       pin_a_invert;
    logic       driver_enable;
    logic [2:0] driver_output_mode;
    logic [1:0] carrier_level_drop;
    logic       carrier_max;
    logic [4:0] residual_carrier;
    logic [3:0] overshoot_length;
    logic [3:0] overshoot_first_value;
    logic [3:0] load_current_trim;
    logic       modulation_invert;
    rftd_src_t  modulation_source;
  } rftd_cfg_t;

  typedef struct packed
  {
    logic       pin_a_out;
    logic       pin_a_oe;
    logic       pin_b_out;
    logic       pin_b_oe;
    logic       modulation;
    logic [10:0] drop_mv;
  } rftd_drv_t;
endpackage

// [rtl/rftd_pin_stage.sv]
// driver pin stage: mode, enable and inversion per pin
module rftd_pin_stage
  import rftd_pkg::*;
(
  input  wire logic CLK_SYS_IN,
  input  wire logic RST_N_IN,
  input  wire logic drive_in,
  input  wire logic enable_in,
  input  wire logic invert_in,
  input  wire logic [2:0] mode_in,
  output logic      pin_out,
  output logic      pin_oe_out
);
`include "rftd_regs.svh"
  typedef struct packed
  {
    logic pin;
    logic oe;
  } rftd_pin_state_t;

  rftd_pin_state_t st_q;
  rftd_pin_state_t st_d;
  logic            lvl;

  always_comb
  begin
    st_d = '0;
    lvl  = drive_in ^ invert_in;                          // [RL1] [RL2]
    if (enable_in)                                        // [RL3]
    begin
      case (mode_in)                                      // [RL4]
        `RFTD_MODE_OPEN_DRAIN:
        begin
          st_d.pin = 1'b0;
          st_d.oe  = ~lvl;
        end
        `RFTD_MODE_PUSH_PULL:
        begin
          st_d.pin = lvl;
          st_d.oe  = 1'b1;
        end
        `RFTD_MODE_FIX_LOW:
        begin
          st_d.pin = invert_in;
          st_d.oe  = 1'b1;
        end
        `RFTD_MODE_FIX_HIGH:
        begin
          st_d.pin = ~invert_in;
          st_d.oe  = 1'b1;
        end
        // high-z and the unsupported codes leave the pin undriven
        default:
        begin
          st_d.pin = 1'b0;
          st_d.oe  = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign pin_out    = st_q.pin;
  assign pin_oe_out = st_q.oe;
endmodule // rftd_pin_stage

// [rtl/rftd_driver_config.sv]
// apb register bank that configures the antenna driver stage
//
// The APB register port was left to the implementer.
module rftd_driver_config
  import rftd_pkg::*;
(
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  input  wire logic [3:0]  PSTRB_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic        CARRIER_IN,
  input  wire logic        INTERNAL_ENVELOPE_IN,
  input  wire logic        EXTERNAL_SERIAL_INPUT_IN,
  output logic             DRIVER_PIN_A_OUT,
  output logic             DRIVER_PIN_A_OE_OUT,
  output logic             DRIVER_PIN_B_OUT,
  output logic             DRIVER_PIN_B_OE_OUT,
  output logic             MODULATION_OUT,
  output logic             CARRIER_MAX_OUT,
  output logic      [10:0] CARRIER_DROP_MV_OUT,
  output logic      [4:0]  RESIDUAL_CARRIER_OUT,
  output logic      [3:0]  OVERSHOOT_LENGTH_OUT,
  output logic      [3:0]  OVERSHOOT_FIRST_VALUE_OUT,
  output logic      [3:0]  LOAD_CURRENT_TRIM_OUT
);
`include "rftd_regs.svh"
  typedef struct packed
  {
    logic [7:0]  drv_mode;
    logic [7:0]  amplitude;
    logic [7:0]  mod_ctrl;
    logic [7:0]  load_trim;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ext_s1;
    logic        ext_s2;
    logic        ext_s3;
    logic        ext_lvl;
    logic        modulation;
    logic        carrier_max;
    logic [10:0] drop_mv;
  } rftd_state_t;

  rftd_state_t st_q;
  rftd_state_t st_d;
  rftd_cfg_t   cfg;
  logic        setup;
  logic        hit;
  logic [7:0]  idx;
  logic [7:0]  wbyte;
  logic        mod_raw;

  // each byte register sits in its own aligned word: index times four
  assign idx   = {2'b00, PADDR_IN[7:2]};
  assign setup = PSEL_IN && !PENABLE_IN;
  assign hit   = (idx == `RFTD_IDX_DRV_MODE) || (idx == `RFTD_IDX_AMPLITUDE) ||
                 (idx == `RFTD_IDX_MOD_CTRL) || (idx == `RFTD_IDX_LOAD_TRIM);
  assign wbyte = PWDATA_IN[7:0];

  assign cfg.pin_b_invert          = st_q.drv_mode[7];
  assign cfg.pin_a_invert          = st_q.drv_mode[6];
  assign cfg.driver_enable         = st_q.drv_mode[3];
  assign cfg.driver_output_mode    = st_q.drv_mode[2:0];
  assign cfg.carrier_level_drop    = st_q.amplitude[7:6];
  assign cfg.residual_carrier      = st_q.amplitude[4:0];
  assign cfg.overshoot_length      = st_q.mod_ctrl[7:4];
  assign cfg.carrier_max           = st_q.mod_ctrl[3];
  assign cfg.modulation_invert     = st_q.mod_ctrl[2];
  assign cfg.modulation_source     = rftd_src_t'(st_q.mod_ctrl[1:0]);
  assign cfg.overshoot_first_value = st_q.load_trim[7:4];
  assign cfg.load_current_trim     = st_q.load_trim[3:0];

  always_comb
  begin
    st_d         = st_q;
    st_d.pready  = 1'b0;
    st_d.pslverr = 1'b0;
    // external input: three flops, a change counts once stages two and three agree
    st_d.ext_s1 = EXTERNAL_SERIAL_INPUT_IN;
    st_d.ext_s2 = st_q.ext_s1;
    st_d.ext_s3 = st_q.ext_s2;
    if (st_q.ext_s2 == st_q.ext_s3)
      st_d.ext_lvl = st_q.ext_s3;
    case (cfg.modulation_source)                          // [RL11]
      RFTD_SRC_ENVELOPE: mod_raw = INTERNAL_ENVELOPE_IN;
      RFTD_SRC_EXTERNAL: mod_raw = st_q.ext_lvl;
      default:           mod_raw = 1'b0;
    endcase
    st_d.modulation  = mod_raw ^ cfg.modulation_invert;   // [RL10]
    st_d.carrier_max = cfg.carrier_max;                   // [RL7]
    if (cfg.carrier_max)                                  // [RL7]
      st_d.drop_mv = 11'd0;
    else
    begin
      case (cfg.carrier_level_drop)                       // [RL6]
        2'h0:    st_d.drop_mv = `RFTD_DROP_MV_0;
        2'h1:    st_d.drop_mv = `RFTD_DROP_MV_1;
        2'h2:    st_d.drop_mv = `RFTD_DROP_MV_2;
        default: st_d.drop_mv = `RFTD_DROP_MV_3;
      endcase
    end
    // answer one cycle after setup; pready high in the first access cycle
    if (setup)
    begin
      st_d.pready  = 1'b1;
      st_d.pslverr = !hit;
      st_d.prdata  = 32'h0000_0000;
      if (PWRITE_IN && hit && PSTRB_IN[0])
      begin
        case (idx)                                        // [RL14]
          `RFTD_IDX_DRV_MODE:
            st_d.drv_mode = wbyte & `RFTD_MASK_DRV_MODE;  // [RL15]
          `RFTD_IDX_AMPLITUDE:
            st_d.amplitude = wbyte & `RFTD_MASK_AMPLITUDE; // [RL15]
          `RFTD_IDX_MOD_CTRL:
            st_d.mod_ctrl = wbyte & `RFTD_MASK_MOD_CTRL;  // [RL9]
          default:
            st_d.load_trim = wbyte & `RFTD_MASK_LOAD_TRIM; // [RL12] [RL13]
        endcase
      end
      else if (!PWRITE_IN)
      begin
        case (idx)                                        // [RL14]
          `RFTD_IDX_DRV_MODE:  st_d.prdata = {24'h00_0000, st_q.drv_mode};
          `RFTD_IDX_AMPLITUDE: st_d.prdata = {24'h00_0000, st_q.amplitude};
          `RFTD_IDX_MOD_CTRL:  st_d.prdata = {24'h00_0000, st_q.mod_ctrl};
          `RFTD_IDX_LOAD_TRIM: st_d.prdata = {24'h00_0000, st_q.load_trim};
          default:             st_d.prdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // write lands at the setup edge; the master still holds it until pready
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
    begin
      st_q            <= '0;
      st_q.drv_mode   <= `RFTD_RST_DRV_MODE;
      st_q.amplitude  <= `RFTD_RST_AMPLITUDE;
      st_q.mod_ctrl   <= `RFTD_RST_MOD_CTRL;
      st_q.load_trim  <= `RFTD_RST_LOAD_TRIM;
      st_q.drop_mv    <= `RFTD_DROP_MV_0;
    end
    else
      st_q <= st_d;
  end

  rftd_pin_stage u_pin_a
  (
    .CLK_SYS_IN (CLK_SYS_IN),
    .RST_N_IN   (RST_N_IN),
    .drive_in   (CARRIER_IN),
    .enable_in  (cfg.driver_enable),
    .invert_in  (cfg.pin_a_invert),
    .mode_in    (cfg.driver_output_mode),
    .pin_out    (DRIVER_PIN_A_OUT),
    .pin_oe_out (DRIVER_PIN_A_OE_OUT)
  );

  rftd_pin_stage u_pin_b
  (
    .CLK_SYS_IN (CLK_SYS_IN),
    .RST_N_IN   (RST_N_IN),
    .drive_in   (CARRIER_IN),
    .enable_in  (cfg.driver_enable),
    .invert_in  (cfg.pin_b_invert),
    .mode_in    (cfg.driver_output_mode),
    .pin_out    (DRIVER_PIN_B_OUT),
    .pin_oe_out (DRIVER_PIN_B_OE_OUT)
  );

  assign PRDATA_OUT                = st_q.prdata;
  assign PREADY_OUT                = st_q.pready;
  assign PSLVERR_OUT               = st_q.pslverr;
  assign MODULATION_OUT            = st_q.modulation;
  assign CARRIER_MAX_OUT           = st_q.carrier_max;
  assign CARRIER_DROP_MV_OUT       = st_q.drop_mv;
  assign RESIDUAL_CARRIER_OUT      = st_q.amplitude[4:0];        // [RL8]
  assign OVERSHOOT_LENGTH_OUT      = st_q.mod_ctrl[7:4];         // [RL9]
  assign OVERSHOOT_FIRST_VALUE_OUT = st_q.load_trim[7:4];        // [RL12]
  assign LOAD_CURRENT_TRIM_OUT     = st_q.load_trim[3:0];        // [RL13]

  a_reserved_zero: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (st_q.drv_mode[5:4] == 2'b00) && !st_q.amplitude[5]) // [RL15]
    else $error("reserved bits not zero");
  a_drop_max_zero: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    cfg.carrier_max |=> CARRIER_DROP_MV_OUT == 11'd0) // [RL7]
    else $error("drop not cleared under max carrier");
  a_drop_code_map: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (!cfg.carrier_max && cfg.carrier_level_drop == 2'h3) |=>
    CARRIER_DROP_MV_OUT == 11'd1000) // [RL6]
    else $error("drop code 3 not 1000 mV");
  a_mod_none_src: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (cfg.modulation_source == RFTD_SRC_NONE) |=>
    MODULATION_OUT == $past(cfg.modulation_invert)) // [RL11]
    else $error("no-source modulation wrong");
  a_mod_envelope: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (cfg.modulation_source == RFTD_SRC_ENVELOPE) |=>
    MODULATION_OUT == ($past(INTERNAL_ENVELOPE_IN) ^
    $past(cfg.modulation_invert))) // [RL10]
    else $error("envelope modulation wrong");
  a_pins_disabled: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    !cfg.driver_enable |=> !DRIVER_PIN_A_OE_OUT && !DRIVER_PIN_B_OE_OUT) // [RL3]
    else $error("pins driven while disabled");
  a_pin_a_invert: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (cfg.driver_enable && cfg.driver_output_mode == 3'h1) |=>
    DRIVER_PIN_A_OUT == ($past(CARRIER_IN) ^ $past(cfg.pin_a_invert))) // [RL2]
    else $error("pin a level wrong");
  a_pin_b_invert: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (cfg.driver_enable && cfg.driver_output_mode == 3'h1) |=>
    DRIVER_PIN_B_OUT == ($past(CARRIER_IN) ^ $past(cfg.pin_b_invert))) // [RL1]
    else $error("pin b level wrong");
  a_high_z_mode: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (cfg.driver_output_mode == 3'h2) |=> !DRIVER_PIN_A_OE_OUT) // [RL4]
    else $error("high-z mode drives pin");
  a_write_lands: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (setup && PWRITE_IN && PSTRB_IN[0] && idx == 8'h2B) |=>
    st_q.load_trim == $past(PWDATA_IN[7:0]) && PREADY_OUT) // [RL14]
    else $error("load register write lost");
endmodule // rftd_driver_config

// [bench/rftd_antenna_model.sv]
// antenna network model: resolves the two driver pin wires
module rftd_antenna_model
(
  input  wire logic clk_in,
  input  wire logic pin_a_in,
  input  wire logic oe_a_in,
  input  wire logic pin_b_in,
  input  wire logic oe_b_in,
  output logic      wire_a_out,
  output logic      wire_b_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_a_q = 1'b0;
  logic last_b_q = 1'b0;
  // no pull on the coil, so an undriven wire keeps toggling
  always @(posedge clk_in)
  begin
    last_a_q <= wire_a_out;
    last_b_q <= wire_b_out;
  end
  assign wire_a_out = oe_a_in ? pin_a_in : !last_a_q;
  assign wire_b_out = oe_b_in ? pin_b_in : !last_b_q;
endmodule // rftd_antenna_model

// [bench/rftd_driver_config_tb.sv]
// self-checking bench of the driver config register bank
module rftd_driver_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_n, psel, penable, pwrite, car, env, ext;
  logic        rdy, serr, pa, pa_oe, pb, pb_oe, modl, cmax, wa, wb;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb, ovl, ovf, trim;
  logic [10:0] drop;
  logic [4:0]  resid;
  logic [7:0]  mir [4];
  logic [7:0]  msk [4] = '{8'hCF, 8'hDF, 8'hFF, 8'hFF};
  logic [2:0]  modes [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5};
  logic [7:0]  bad [3] = '{8'h9C, 8'hB0, 8'hFC};
  integer      seed = 82499;
  integer      miscompares = 0;
  integer      total_checks = 0;
  integer      cyc = 0;

  rftd_driver_config rftd_driver_config_i (.CLK_SYS_IN(clk), .RST_N_IN(rst_n),
    .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb),
    .PRDATA_OUT(prdata), .PREADY_OUT(rdy), .PSLVERR_OUT(serr),
    .CARRIER_IN(car), .INTERNAL_ENVELOPE_IN(env),
    .EXTERNAL_SERIAL_INPUT_IN(ext), .DRIVER_PIN_A_OUT(pa),
    .DRIVER_PIN_A_OE_OUT(pa_oe), .DRIVER_PIN_B_OUT(pb),
    .DRIVER_PIN_B_OE_OUT(pb_oe), .MODULATION_OUT(modl),
    .CARRIER_MAX_OUT(cmax), .CARRIER_DROP_MV_OUT(drop),
    .RESIDUAL_CARRIER_OUT(resid), .OVERSHOOT_LENGTH_OUT(ovl),
    .OVERSHOOT_FIRST_VALUE_OUT(ovf), .LOAD_CURRENT_TRIM_OUT(trim));

  rftd_antenna_model rftd_antenna_model_i (.clk_in(clk), .pin_a_in(pa),
    .oe_a_in(pa_oe), .pin_b_in(pb), .oe_b_in(pb_oe),
    .wire_a_out(wa), .wire_b_out(wb));

  initial
  begin
    forever #20 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // request held until the rising edge that samples pready high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [7:0] d, output logic [31:0] rd,
                     output logic err);
    logic [31:0] r;
    int          n;
    r = $random(seed);
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {r[31:8], d};
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rdy !== 1'b1 && n < 20);
    rd  = prdata;
    err = serr;
    if (n >= 20)
      chk(32'h0, 32'h1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [7:0] addr(int i);
    return 8'(4 * (32'h28 + i));
  endfunction

  // returns {level, drive}; level counts only while driving
  function automatic logic [1:0] pin_exp(logic inv, logic [7:0] c);
    logic v;
    v = car ^ inv;
    if (!c[3])
      return 2'b00;
    case (c[2:0])
      3'h0: return {1'b0, !v};
      3'h1: return {v, 1'b1};
      3'h4: return {inv, 1'b1};
      3'h5: return {!inv, 1'b1};
      default: return 2'b00;
    endcase
  endfunction

  function automatic logic [10:0] drop_exp();
    logic [10:0] t [4] = '{11'd100, 11'd250, 11'd500, 11'd1000};
    return mir[2][3] ? 11'd0 : t[mir[1][7:6]];
  endfunction

  function automatic logic mod_exp();
    logic s;
    s = (mir[2][1:0] == 2'h1) ? env : (mir[2][1:0] == 2'h2) ? ext : 1'b0;
    return s ^ mir[2][2];
  endfunction

  task automatic check_outs();
    chk(32'({pa_oe ? wa : 1'b0, pa_oe}), 32'(pin_exp(mir[0][6], mir[0])));
    chk(32'({pb_oe ? wb : 1'b0, pb_oe}), 32'(pin_exp(mir[0][7], mir[0])));
    chk(32'(drop), 32'(drop_exp()));
    chk(32'(cmax), 32'(mir[2][3]));
    chk(32'(resid), 32'(mir[1][4:0]));
    chk(32'(ovl), 32'(mir[2][7:4]));
    chk(32'(modl), 32'(mod_exp()));
    chk(32'(ovf), 32'(mir[3][7:4]));
    chk(32'(trim), 32'(mir[3][3:0]));
  endtask

  initial
  begin
    logic [31:0] rd;
    logic        err;
    logic [7:0]  d;
    {rst_n, psel, penable, pwrite, car, env, ext} = '0;
    {paddr, pwdata, pstrb} = '0;
    mir = '{8'h00, 8'h00, 8'h00, 8'h00};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 60; k++)
    begin
      for (int i = 0; i < 4; i++)
      begin
        apb(1'b0, addr(i), 8'h00, rd, err);
        chk(rd, 32'(mir[i]));
        chk(32'(err), 32'h0);
        d = 8'($random(seed));
        if (i == 0 && k < 20)
          d[2:0] = modes[k % 5];
        if (i == 0 && (d[2:0] == 3'h3 || d[2:0] == 3'h6))
          d[2:0] = 3'h1;
        if (i == 2 && k < 8)
          d[3:0] = 4'(k);
        pstrb <= 4'h1 | 4'($random(seed));
        apb(1'b1, addr(i), d, rd, err);
        mir[i] = d & msk[i];
      end
      car <= 1'($random(seed));
      env <= 1'($random(seed));
      ext <= 1'($random(seed));
      repeat (6) @(posedge clk);
      @(negedge clk);
      check_outs();
    end
    // refused writes: no strobe on the low byte, then unmapped words
    pstrb <= 4'hE;
    apb(1'b1, addr(1), ~mir[1], rd, err);
    pstrb <= 4'hF;
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, bad[i], 8'hFF, rd, err);
      chk(32'(err), 32'h1);
      apb(1'b0, bad[i], 8'h00, rd, err);
      chk({rd[31:1], err}, 32'h1);
    end
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, addr(i), 8'h00, rd, err);
      chk(rd, 32'(mir[i]));
    end
    report_and_stop();
  end
endmodule // rftd_driver_config_tb
